// ---- rtl/tlv_xfer_pkg.sv ----
// Notes on behaviour
// - object is tag, length, then value bytes
// - primitive tags 80-9E, 9F1F-9F7F, 9F81XX-9FFFXX
// - constructed tags A0-BE, BF1F-BF7F, BF81XX-BFFFXX
// - out-of-range tag rejected, wrong data status
// - length uses minimal 81/82/83 prefixed encoding
// - tag 5C returns list of top tags
// - transfer state kept per logical channel
// - first block starts, next blocks continue
// - non-final blocks answer with more-data status
// - file or pointer change aborts open transfer
// - good first block sets pointer, aborts transfer
// - error status leaves pointer and offset unchanged
// - retransmit only after good answer, same parameters
// - retrieve needs read access on current file
// - absent object answers data not found
// - object held by other store: conditions not met
// - more data outstanding completes with 62F1/62F2
// - next block after full retrieval gives 6A86
// - selector b8b7 decodes first/next/retransmit/reserved
// - first gives segment, next continues, retransmit repeats
package tlv_xfer_pkg;
  localparam int CHANNELS  = 4;
  localparam int CH_W      = 2;
  localparam int OFS_W     = 24;
  localparam int SEG_W     = 8;
  localparam int TAG_W     = 24;
  localparam int SFI_W     = 5;

  localparam logic [7:0] TAG_LIST       = 8'h5C;
  localparam logic [7:0] PRIM_FIRST     = 8'h80;
  localparam logic [7:0] PRIM_LAST      = 8'h9E;
  localparam logic [7:0] PRIM_ESC       = 8'h9F;
  localparam logic [7:0] CONS_FIRST     = 8'hA0;
  localparam logic [7:0] CONS_LAST      = 8'hBE;
  localparam logic [7:0] CONS_ESC       = 8'hBF;
  localparam logic [7:0] TAG2_FIRST     = 8'h1F;
  localparam logic [7:0] TAG2_LAST      = 8'h7F;
  localparam logic [7:0] TAG3_FIRST     = 8'h81;
  localparam logic [7:0] TAG3_TAIL_LAST = 8'h7F;

  localparam logic [7:0] LEN_SHORT_MAX  = 8'h7F;
  localparam logic [7:0] LEN_PFX_1      = 8'h81;
  localparam logic [7:0] LEN_PFX_2      = 8'h82;
  localparam logic [7:0] LEN_PFX_3      = 8'h83;

  localparam logic [1:0] SEL_FIRST      = 2'h2;
  localparam logic [1:0] SEL_NEXT       = 2'h0;
  localparam logic [1:0] SEL_RETX       = 2'h1;
  localparam int         SEL_MODE_HI    = 7;
  localparam int         SEL_MODE_LO    = 6;
  localparam int         SEL_SFI_HI     = 4;

  localparam logic [15:0] SW_OK         = 16'h9000;
  localparam logic [15:0] SW_MORE_1     = 16'h62F1;
  localparam logic [15:0] SW_MORE_2     = 16'h62F2;
  localparam logic [15:0] SW_BAD_DATA   = 16'h6A80;
  localparam logic [15:0] SW_NOT_FOUND  = 16'h6A88;
  localparam logic [15:0] SW_COND_USE   = 16'h6985;
  localparam logic [15:0] SW_BAD_P1P2   = 16'h6A86;
  localparam logic [15:0] SW_SECURITY   = 16'h6982;

  localparam logic [OFS_W-1:0] OFS_RESET = 24'h00_0000;

  typedef enum logic [1:0] {
    TAG_BAD,
    TAG_PRIM,
    TAG_CONS
  } tag_class_type;
endpackage : tlv_xfer_pkg

// ---- rtl/tlv_tag_check.sv ----
`timescale 1ns/100ps
// combinational tag range classifier
module tlv_tag_check (
  input  wire logic [23:0]              tag,
  input  wire logic [1:0]               tag_len,
  output tlv_xfer_pkg::tag_class_type   tag_class
);
  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] b2;
  logic       esc;
  assign b0 = tag[23:16];
  assign b1 = tag[15:8];
  assign b2 = tag[7:0];

  always_comb begin
    esc = 1'b0;
    tag_class = tlv_xfer_pkg::TAG_BAD;
    unique case (tag_len)
      2'd1: begin
        if (b0 >= tlv_xfer_pkg::PRIM_FIRST && b0 <= tlv_xfer_pkg::PRIM_LAST)
          tag_class = tlv_xfer_pkg::TAG_PRIM;
        else if (b0 >= tlv_xfer_pkg::CONS_FIRST
                 && b0 <= tlv_xfer_pkg::CONS_LAST)
          tag_class = tlv_xfer_pkg::TAG_CONS;
      end
      2'd2: begin
        esc = b1 >= tlv_xfer_pkg::TAG2_FIRST && b1 <= tlv_xfer_pkg::TAG2_LAST;
        if (esc && b0 == tlv_xfer_pkg::PRIM_ESC)
          tag_class = tlv_xfer_pkg::TAG_PRIM;
        else if (esc && b0 == tlv_xfer_pkg::CONS_ESC)
          tag_class = tlv_xfer_pkg::TAG_CONS;
      end
      2'd3: begin
        esc = b1 >= tlv_xfer_pkg::TAG3_FIRST
              && b2 <= tlv_xfer_pkg::TAG3_TAIL_LAST;
        if (esc && b0 == tlv_xfer_pkg::PRIM_ESC)
          tag_class = tlv_xfer_pkg::TAG_PRIM;
        else if (esc && b0 == tlv_xfer_pkg::CONS_ESC)
          tag_class = tlv_xfer_pkg::TAG_CONS;
      end
      default: tag_class = tlv_xfer_pkg::TAG_BAD;
    endcase
  end
endmodule : tlv_tag_check

// ---- rtl/tlv_chan_mem.sv ----
`timescale 1ns/100ps
// per-channel transfer context store, registered read
module tlv_chan_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int AW    = 2
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_rd_data;

  always_comb begin
    next_rd_data = mem[rd_addr];
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      rd_data <= '0;
    end else begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= next_rd_data;
    end
  end
endmodule : tlv_chan_mem

// ---- rtl/tlv_object_transfer.sv ----
`timescale 1ns/100ps
// ---------------------------------------------------------------
// retrieve command engine with per-channel segmentation context
// ---------------------------------------------------------------
// a command is taken on cmd_valid; the context of its channel is
// read from memory (one cycle), then decided (one cycle). the
// object store answers obj_* combinationally for the current tag.
module tlv_object_transfer (
  input  wire logic                      ref_clk,
  input  wire logic                      sys_rst,
  input  wire logic                      cmd_valid,
  input  wire logic [1:0]                cmd_channel,
  input  wire logic [7:0]                cmd_selector,
  input  wire logic [23:0]               cmd_tag,
  input  wire logic [1:0]                cmd_tag_len,
  input  wire logic [7:0]                cmd_seg_len,
  input  wire logic                      cmd_file_change,
  input  wire logic                      read_allowed,
  input  wire logic                      obj_present,
  input  wire logic                      obj_held_other,
  input  wire logic [23:0]               obj_len,
  input  wire logic                      proactive_pending,
  output logic                           rsp_valid,
  output logic [15:0]                    rsp_status,
  output logic [23:0]                    rsp_offset,
  output logic [7:0]                     rsp_count,
  output logic                           rsp_tag_list,
  output logic [23:0]                    cur_tag,
  output logic                           cmd_ready
);
  // ---------------------------------------------------------------
  // context record
  // ---------------------------------------------------------------
  // {active, done, ok_prev, tag[24], offset[24], prev_offset[24],
  //  prev_count[8]}
  localparam int CTX_W = 3 + 24 + 24 + 24 + 8;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_DECIDE
  } state_type;

  state_type  state;
  state_type  next_state;

  logic [1:0]       chan;
  logic [7:0]       sel;
  logic [23:0]      tag;
  logic [1:0]       tag_len;
  logic [7:0]       seg;
  logic             file_chg;
  logic [1:0]       next_chan;
  logic [7:0]       next_sel;
  logic [23:0]      next_tag;
  logic [1:0]       next_tag_len;
  logic [7:0]       next_seg;
  logic             next_file_chg;

  logic             next_rsp_valid;
  logic [15:0]      next_rsp_status;
  logic [23:0]      next_rsp_offset;
  logic [7:0]       next_rsp_count;
  logic             next_rsp_tag_list;
  logic [23:0]      next_cur_tag;

  logic             wr_en;
  logic [CTX_W-1:0] wr_ctx;
  logic [CTX_W-1:0] rd_ctx;

  logic             c_active;
  logic             c_done;
  logic             c_ok_prev;
  logic [23:0]      c_tag;
  logic [23:0]      c_ofs;
  logic [23:0]      c_pofs;
  logic [7:0]       c_pcnt;

  tlv_xfer_pkg::tag_class_type tag_class;

  assign {c_active, c_done, c_ok_prev, c_tag, c_ofs, c_pofs, c_pcnt} = rd_ctx;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  tlv_tag_check u_tag_check (
    .tag       (tag),
    .tag_len   (tag_len),
    .tag_class (tag_class)
  );

  tlv_chan_mem #(
    .WIDTH (CTX_W),
    .DEPTH (tlv_xfer_pkg::CHANNELS),
    .AW    (tlv_xfer_pkg::CH_W)
  ) u_ctx (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_en),
    .wr_addr (chan),
    .wr_data (wr_ctx),
    .rd_addr (chan),
    .rd_data (rd_ctx)
  );

  // ---------------------------------------------------------------
  // decision
  // ---------------------------------------------------------------
  logic [1:0]  mode;
  logic        sfi_zero;
  logic [23:0] remain;
  logic [7:0]  take;
  logic        is_list;
  logic [1:0]  ctx_tlen;
  logic [1:0]  hdr_tlen;
  logic [2:0]  len_bytes;
  logic [23:0] total;
  logic [tlv_xfer_pkg::CHANNELS-1:0] ok_last;
  logic [tlv_xfer_pkg::CHANNELS-1:0] next_ok_last;

  always_comb begin
    mode     = sel[tlv_xfer_pkg::SEL_MODE_HI:tlv_xfer_pkg::SEL_MODE_LO];
    sfi_zero = sel[tlv_xfer_pkg::SEL_SFI_HI:0] == 5'h00;
    is_list  = tag_len == 2'd1 && tag[23:16] == tlv_xfer_pkg::TAG_LIST;
    remain   = 24'h00_0000;
    take     = 8'h00;
    // segments cover tag, length field and value. the total is only
    // 24 bits like the offset, so the few largest lengths wrap
    ctx_tlen  = (c_tag[20:16] != 5'h1F) ? 2'h1
                : (c_tag[15] ? 2'h3 : 2'h2);
    hdr_tlen  = (mode == tlv_xfer_pkg::SEL_FIRST) ? tag_len : ctx_tlen;
    len_bytes = (obj_len <= {16'h0000, tlv_xfer_pkg::LEN_SHORT_MAX}) ? 3'h1
                : (obj_len[23:8] == 16'h0000) ? 3'h2
                : (obj_len[23:16] == 8'h00) ? 3'h3 : 3'h4;
    total     = obj_len + 24'(hdr_tlen) + 24'(len_bytes);

    next_state        = state;
    next_chan         = chan;
    next_sel          = sel;
    next_tag          = tag;
    next_tag_len      = tag_len;
    next_seg          = seg;
    next_file_chg     = file_chg;
    next_rsp_valid    = 1'b0;
    next_rsp_status   = rsp_status;
    next_rsp_offset   = rsp_offset;
    next_rsp_count    = rsp_count;
    next_rsp_tag_list = rsp_tag_list;
    next_cur_tag      = cur_tag;
    wr_en             = 1'b0;
    wr_ctx            = rd_ctx;
    next_ok_last      = ok_last;

    unique case (state)
      ST_IDLE: begin
        if (cmd_valid) begin
          next_chan     = cmd_channel;
          next_sel      = cmd_selector;
          next_tag      = cmd_tag;
          next_tag_len  = cmd_tag_len;
          next_seg      = cmd_seg_len;
          next_file_chg = cmd_file_change;
          next_state    = ST_FETCH;
        end
      end
      ST_FETCH: begin
        next_state = ST_DECIDE;
      end
      ST_DECIDE: begin
        next_state     = ST_IDLE;
        next_rsp_valid = 1'b1;
        next_rsp_tag_list = 1'b0;
        next_rsp_status   = tlv_xfer_pkg::SW_BAD_P1P2;
        if (file_chg) begin
          // a file change drops the open transfer but is not a retrieve
          wr_en           = 1'b1;
          wr_ctx          = '0;
          next_rsp_status = tlv_xfer_pkg::SW_OK;
        end else if (!read_allowed) begin
          next_rsp_status = tlv_xfer_pkg::SW_SECURITY;
        end else if (mode == tlv_xfer_pkg::SEL_FIRST) begin
          if (!is_list && tag_class == tlv_xfer_pkg::TAG_BAD) begin
            next_rsp_status = tlv_xfer_pkg::SW_BAD_DATA;
          end else if (!is_list && !obj_present) begin
            next_rsp_status = tlv_xfer_pkg::SW_NOT_FOUND;
          end else if (!is_list && obj_held_other) begin
            next_rsp_status = tlv_xfer_pkg::SW_COND_USE;
          end else begin
            // restart from zero even for the same tag
            take = (total > {16'h0000, seg}) ? seg : total[7:0];
            if (is_list) begin
              take = seg;
            end
            next_rsp_tag_list = is_list;
            next_cur_tag    = tag;
            next_rsp_offset = tlv_xfer_pkg::OFS_RESET;
            next_rsp_count  = take;
            wr_en  = 1'b1;
            wr_ctx = {1'b1, 1'b0, 1'b1, tag, {16'h0000, take},
                      tlv_xfer_pkg::OFS_RESET, take};
            if (!is_list && total > {16'h0000, take}) begin
              next_rsp_status = proactive_pending ? tlv_xfer_pkg::SW_MORE_2
                                : tlv_xfer_pkg::SW_MORE_1;
            end else begin
              next_rsp_status = tlv_xfer_pkg::SW_OK;
              wr_ctx[CTX_W-2] = 1'b1;
            end
          end
        end else if (mode == tlv_xfer_pkg::SEL_NEXT && sfi_zero) begin
          if (c_active && !c_done) begin
            remain = total - c_ofs;
            take   = (remain > {16'h0000, seg}) ? seg : remain[7:0];
            next_rsp_offset = c_ofs;
            next_cur_tag    = c_tag;
            next_rsp_count  = take;
            wr_en  = 1'b1;
            wr_ctx = {1'b1, 1'b0, 1'b1, c_tag, c_ofs + {16'h0000, take},
                      c_ofs, take};
            if (remain > {16'h0000, take}) begin
              next_rsp_status = proactive_pending ? tlv_xfer_pkg::SW_MORE_2
                                : tlv_xfer_pkg::SW_MORE_1;
            end else begin
              next_rsp_status = tlv_xfer_pkg::SW_OK;
              wr_ctx[CTX_W-2] = 1'b1;
            end
          end else begin
            next_rsp_status = tlv_xfer_pkg::SW_BAD_P1P2;
          end
        end else if (mode == tlv_xfer_pkg::SEL_RETX && sfi_zero) begin
          if (c_active && c_ok_prev && ok_last[chan]
              && seg == c_pcnt) begin
            next_rsp_offset = c_pofs;
            next_rsp_count  = c_pcnt;
            next_cur_tag    = c_tag;
            next_rsp_status = (c_ofs < total)
                              ? tlv_xfer_pkg::SW_MORE_1 : tlv_xfer_pkg::SW_OK;
          end
        end
        // error paths above never write the context
        // the good-answer flag lives outside the context for that reason
        next_ok_last[chan] = next_rsp_status == tlv_xfer_pkg::SW_OK
                             || next_rsp_status == tlv_xfer_pkg::SW_MORE_1
                             || next_rsp_status == tlv_xfer_pkg::SW_MORE_2;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state        <= ST_IDLE;
      chan         <= 2'h0;
      sel          <= 8'h00;
      tag          <= 24'h00_0000;
      tag_len      <= 2'h0;
      seg          <= 8'h00;
      file_chg     <= 1'b0;
      rsp_valid    <= 1'b0;
      rsp_status   <= tlv_xfer_pkg::SW_OK;
      rsp_offset   <= tlv_xfer_pkg::OFS_RESET;
      rsp_count    <= 8'h00;
      rsp_tag_list <= 1'b0;
      cur_tag      <= 24'h00_0000;
      ok_last      <= '0;
      cmd_ready    <= 1'b0;
    end else begin
      state        <= next_state;
      chan         <= next_chan;
      sel          <= next_sel;
      tag          <= next_tag;
      tag_len      <= next_tag_len;
      seg          <= next_seg;
      file_chg     <= next_file_chg;
      rsp_valid    <= next_rsp_valid;
      rsp_status   <= next_rsp_status;
      rsp_offset   <= next_rsp_offset;
      rsp_count    <= next_rsp_count;
      rsp_tag_list <= next_rsp_tag_list;
      cur_tag      <= next_cur_tag;
      ok_last      <= next_ok_last;
      cmd_ready    <= next_state == ST_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence cmd_taken;
    state == ST_IDLE && cmd_valid;
  endsequence

  AST_ANSWER_3: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cmd_taken |-> ##3 rsp_valid)
    else $error("answer not three cycles after command");
  AST_BAD_TAG: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state == ST_DECIDE && !file_chg && read_allowed
    && mode == tlv_xfer_pkg::SEL_FIRST && !is_list
    && tag_class == tlv_xfer_pkg::TAG_BAD
    |=> rsp_status == tlv_xfer_pkg::SW_BAD_DATA)
    else $error("bad tag not rejected");
  AST_NO_READ: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state == ST_DECIDE && !file_chg && !read_allowed
    |=> rsp_status == tlv_xfer_pkg::SW_SECURITY)
    else $error("retrieve without read access");
  AST_ERR_KEEP: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state == ST_DECIDE && !file_chg && !read_allowed |-> !wr_en)
    else $error("error wrote context");
  AST_DONE_6A86: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state == ST_DECIDE && !file_chg && read_allowed && c_done
    && mode == tlv_xfer_pkg::SEL_NEXT
    |=> rsp_status == tlv_xfer_pkg::SW_BAD_P1P2)
    else $error("next after done not rejected");
  AST_MORE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rsp_valid && rsp_status == tlv_xfer_pkg::SW_OK && !rsp_tag_list
    |-> $past(wr_en) || $past(mode) == tlv_xfer_pkg::SEL_RETX
    || $past(file_chg))
    else $error("ok without final segment");
  AST_ABORT: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state == ST_DECIDE && file_chg |-> wr_en && wr_ctx == '0)
    else $error("file change did not abort");
  AST_NOT_FOUND: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state == ST_DECIDE && !file_chg && read_allowed
    && mode == tlv_xfer_pkg::SEL_FIRST && !is_list
    && tag_class != tlv_xfer_pkg::TAG_BAD && !obj_present
    |=> rsp_status == tlv_xfer_pkg::SW_NOT_FOUND)
    else $error("absent object not reported");
endmodule : tlv_object_transfer

// ---- dv/tlv_terminal_model.sv ----
`timescale 1ns/100ps
// ---------------------------------------------------------------
// terminal side: one command at a time, then waits for the answer
// ---------------------------------------------------------------
module tlv_terminal_model (
  input  wire logic        ref_clk,
  input  wire logic        cmd_ready,
  input  wire logic        rsp_valid,
  output logic             cmd_valid,
  output logic [1:0]       cmd_channel,
  output logic [7:0]       cmd_selector,
  output logic [23:0]      cmd_tag,
  output logic [1:0]       cmd_tag_len,
  output logic [7:0]       cmd_seg_len,
  output logic             cmd_file_change
);
  initial begin
    cmd_valid       = 1'b0;
    cmd_channel     = 2'h0;
    cmd_selector    = 8'h00;
    cmd_tag         = 24'h00_0000;
    cmd_tag_len     = 2'h1;
    cmd_seg_len     = 8'h01;
    cmd_file_change = 1'b0;
  end

  // callers pick a fresh tag for each object
  // between blocks of one channel only next/retransmit/reserved, rejected firsts, a restart or a file change
  task automatic issue(input logic [1:0] ch, input logic [7:0] sel,
                       input logic [23:0] tag, input logic [1:0] tl,
                       input logic [7:0] seg, input logic fc,
                       output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    @(posedge ref_clk);
    cmd_valid       <= 1'b1;
    cmd_channel     <= ch;
    cmd_selector    <= sel;
    cmd_tag         <= tag;
    cmd_tag_len     <= tl;
    cmd_seg_len     <= seg;
    cmd_file_change <= fc;
    @(posedge ref_clk);
    while (cmd_ready !== 1'b1 && n < 20) begin
      n++;
      @(posedge ref_clk);
    end
    // released lines must not keep looking valid
    cmd_valid       <= 1'b0;
    cmd_channel     <= ~ch;
    cmd_selector    <= ~sel;
    cmd_tag         <= ~tag;
    cmd_tag_len     <= ~tl;
    cmd_seg_len     <= ~seg;
    cmd_file_change <= ~fc;
    for (int i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      #1;
      if (rsp_valid === 1'b1) begin
        ok = 1'b1;
        break;
      end
    end
  endtask : issue
endmodule : tlv_terminal_model

// ---- dv/test_tlv_object_transfer.sv ----
`timescale 1ns/100ps
// ---------------------------------------------------------------
// retrieve engine bench: corner and random tags, segmentation
// ---------------------------------------------------------------
module test_tlv_object_transfer;
  logic        ref_clk, sys_rst, read_allowed, obj_present;
  logic        obj_held_other, proactive_pending, ok, pro;
  logic [23:0] obj_len, t;
  logic [1:0]  n;
  logic [7:0]  seg;
  int unsigned v, sz;
  int          errors, compares;
  wire logic        cmd_valid, cmd_file_change, rsp_valid;
  wire logic        rsp_tag_list, cmd_ready;
  wire logic [1:0]  cmd_channel, cmd_tag_len;
  wire logic [7:0]  cmd_selector, cmd_seg_len, rsp_count;
  wire logic [23:0] cmd_tag, rsp_offset, cur_tag;
  wire logic [15:0] rsp_status;
  localparam logic [23:0] T1 = 24'h9F_2000;
  logic [23:0] ct [16] = '{24'h80_0000, 24'h9E_0000, 24'h9F_0000,
    24'h7F_0000, 24'hA0_0000, 24'hBE_0000, 24'hC0_0000, 24'h9F_1E00,
    24'h9F_1F00, 24'h9F_7F00, 24'h9F_8000, 24'hBF_1F00, 24'h9F_8100,
    24'h9F_FF7F, 24'hBF_8180, 24'hBF_817F};
  logic [1:0] cn [16] = '{1, 1, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2, 3, 3, 3, 3};
  // {allowed, present, held}, selector, tag, status
  logic [2:0]  ef [7] = '{3'h3, 3'h4, 3'h7, 3'h6, 3'h6, 3'h6, 3'h6};
  logic [7:0]  es [7] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'hC0, 8'h05, 8'h40};
  logic [23:0] et [7] = '{T1, 24'h9F_2100, 24'h9F_2100, 24'h9F_1000,
    T1, T1, T1};
  logic [15:0] ew [7] = '{16'h6982, 16'h6A88, 16'h6985, 16'h6A80,
    16'h6A86, 16'h6A86, 16'h6A86};

  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;

  tlv_object_transfer i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd_channel(cmd_channel),
    .cmd_selector(cmd_selector), .cmd_tag(cmd_tag),
    .cmd_tag_len(cmd_tag_len), .cmd_seg_len(cmd_seg_len),
    .cmd_file_change(cmd_file_change), .read_allowed(read_allowed),
    .obj_present(obj_present), .obj_held_other(obj_held_other),
    .obj_len(obj_len), .proactive_pending(proactive_pending),
    .rsp_valid(rsp_valid), .rsp_status(rsp_status),
    .rsp_offset(rsp_offset), .rsp_count(rsp_count),
    .rsp_tag_list(rsp_tag_list), .cur_tag(cur_tag),
    .cmd_ready(cmd_ready));

  tlv_terminal_model i_term (.ref_clk(ref_clk), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .cmd_valid(cmd_valid),
    .cmd_channel(cmd_channel), .cmd_selector(cmd_selector),
    .cmd_tag(cmd_tag), .cmd_tag_len(cmd_tag_len),
    .cmd_seg_len(cmd_seg_len), .cmd_file_change(cmd_file_change));

  function automatic logic tag_good(logic [23:0] tg, logic [1:0] k);
    logic [7:0] a, b;
    a = tg[23:16];
    b = tg[15:8];
    case (k)
      2'h1: return (a >= 8'h80 && a <= 8'h9E) || (a >= 8'hA0 && a <= 8'hBE);
      2'h2: return (a == 8'h9F || a == 8'hBF) && b >= 8'h1F && b <= 8'h7F;
      2'h3: return (a == 8'h9F || a == 8'hBF) && b >= 8'h81
                   && tg[7:0] <= 8'h7F;
      default: return 1'b0;
    endcase
  endfunction : tag_good

  // whole object: tag bytes, shortest length field, value
  function automatic int unsigned obj_size(int unsigned k, int unsigned x);
    return k + x + (x < 128 ? 1 : x < 256 ? 2 : x < 65536 ? 3 : 4);
  endfunction : obj_size

  task automatic summarize;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic chk_sw(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: status %h expected %h", $time, got, exp);
    end
  endtask : chk_sw

  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: value %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic store(input logic [2:0] f, input logic [23:0] len);
    {read_allowed, obj_present, obj_held_other} <= f;
    obj_len <= len;
  endtask : store

  task automatic run(input logic [1:0] ch, input logic [7:0] sel,
                     input logic [23:0] tg, input logic [1:0] k,
                     input logic [7:0] sl, input logic fc);
    i_term.issue(ch, sel, tg, k, sl, fc, ok);
    if (ok !== 1'b1) begin
      errors++;
      $display("ERROR at %0t: answer %h expected %h", $time, ok, 1'b1);
      summarize();
    end
  endtask : run

  task automatic expect_rsp(input logic [15:0] sw, input int unsigned off,
                            input int unsigned cnt);
    chk_sw(rsp_status, sw);
    chk_val(rsp_offset, 24'(off));
    chk_val(24'(rsp_count), 24'(cnt));
  endtask : expect_rsp

  initial begin
    sys_rst = 1'b1;
    proactive_pending = 1'b0;
    read_allowed = 1'b1;
    obj_present = 1'b1;
    obj_held_other = 1'b0;
    obj_len = 24'h00_0000;
    errors = 0;
    compares = 0;
    void'($urandom(32'h5cf6));
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk_val(24'(rsp_valid), 24'h00_0000);
    chk_sw(rsp_status, 16'h9000);
    chk_val(24'(cmd_ready), 24'h00_0001);
    $display("test reset done");

    for (int i = 0; i < 56; i++) begin
      if (i < 16) begin
        t = ct[i];
        n = cn[i];
      end else begin
        n = 2'($urandom_range(3, 1));
        t = {8'($urandom_range(8'hC0, 8'h7F)), 16'($urandom)};
        t = n == 2'h1 ? {t[23:16], 16'h0000} :
            n == 2'h2 ? {t[23:8], 8'h00} : t;
      end
      v = $urandom_range(400, 0);
      seg = 8'($urandom_range(255, 1));
      pro = 1'($urandom);
      sz = obj_size(n, v);
      store(3'h6, 24'(v));
      proactive_pending <= pro;
      run(2'($urandom), 8'h80, t, n, seg, 1'b0);
      if (!tag_good(t, n)) begin
        chk_sw(rsp_status, 16'h6A80);
      end else begin
        expect_rsp(sz > seg ? (pro ? 16'h62F2 : 16'h62F1) : 16'h9000,
                   0, sz > seg ? seg : sz);
        chk_val(cur_tag, t);
        chk_val(24'(rsp_tag_list), 24'h00_0000);
      end
    end
    proactive_pending <= 1'b0;
    $display("test tag ranges done");

    store(3'h6, 24'd300);
    proactive_pending <= 1'b1;
    run(2'h1, 8'h80, T1, 2'h2, 8'h64, 1'b0);
    expect_rsp(16'h62F2, 0, 100);
    proactive_pending <= 1'b0;
    store(3'h6, 24'd10);
    run(2'h2, 8'h80, 24'h85_0000, 2'h1, 8'h64, 1'b0);
    expect_rsp(16'h9000, 0, 12);
    store(3'h6, 24'd300);
    run(2'h1, 8'h00, T1, 2'h2, 8'h64, 1'b0);
    expect_rsp(16'h62F1, 100, 100);
    run(2'h1, 8'h40, T1, 2'h2, 8'h64, 1'b0);
    expect_rsp(16'h62F1, 100, 100);
    for (int i = 0; i < 7; i++) begin
      store(ef[i], 24'd300);
      run(2'h1, es[i], et[i], 2'h2, 8'h64, 1'b0);
      chk_sw(rsp_status, ew[i]);
      chk_val(cur_tag, T1);
    end
    store(3'h6, 24'd300);
    run(2'h1, 8'h00, T1, 2'h2, 8'h64, 1'b0);
    expect_rsp(16'h62F1, 200, 100);
    run(2'h1, 8'h00, T1, 2'h2, 8'h64, 1'b0);
    expect_rsp(16'h9000, 300, 5);
    run(2'h1, 8'h00, T1, 2'h2, 8'h64, 1'b0);
    chk_sw(rsp_status, 16'h6A86);
    $display("test segmented retrieve done");

    store(3'h6, 24'd200);
    run(2'h3, 8'h80, 24'h81_0000, 2'h1, 8'h32, 1'b0);
    expect_rsp(16'h62F1, 0, 50);
    run(2'h3, 8'h00, 24'h81_0000, 2'h1, 8'h32, 1'b0);
    expect_rsp(16'h62F1, 50, 50);
    run(2'h3, 8'h80, 24'h81_0000, 2'h1, 8'h32, 1'b0);
    expect_rsp(16'h62F1, 0, 50);
    run(2'h3, 8'h00, 24'h81_0000, 2'h1, 8'h32, 1'b0);
    chk_val(rsp_offset, 24'd50);
    run(2'h3, 8'h00, 24'h81_0000, 2'h1, 8'h32, 1'b1);
    chk_sw(rsp_status, 16'h9000);
    run(2'h3, 8'h00, 24'h81_0000, 2'h1, 8'h32, 1'b0);
    chk_sw(rsp_status, 16'h6A86);
    run(2'h0, 8'h00, 24'h81_0000, 2'h1, 8'h32, 1'b1);
    chk_sw(rsp_status, 16'h9000);
    run(2'h0, 8'h40, 24'h81_0000, 2'h1, 8'h32, 1'b0);
    chk_sw(rsp_status, 16'h6A86);
    run(2'h0, 8'h80, 24'h5C_0000, 2'h1, 8'h28, 1'b0);
    chk_sw(rsp_status, 16'h9000);
    chk_val(24'(rsp_count), 24'd40);
    chk_val(24'(rsp_tag_list), 24'h00_0001);
    $display("test abort and tag list done");
    summarize();
  end
endmodule : test_tlv_object_transfer
